// ### rtl/extreme_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the tracked extremes from the tracker to the main core
interface extreme_if #(parameter int W = 10);
    logic signed [W:0] maxV;
    logic signed [W:0] minV;
    logic clear;
    modport tracker (output maxV, output minV, input clear);
    modport core (input maxV, input minV, output clear);
endinterface : extreme_if
`default_nettype wire

// ### rtl/peak_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module peak_tracker #(
    parameter int W = 10
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic signed [W:0] sample,
    extreme_if.tracker ext
);
    logic signed [W:0] maxQ;
    logic signed [W:0] minQ;

    // Running max and min of the corrected signal since last clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            maxQ <= '0;
            minQ <= '0;
        end else if (ext.clear || !enable) begin
            maxQ <= sample;
            minQ <= sample;
        end else begin
            if (sample > maxQ) maxQ <= sample;
            if (sample < minQ) minQ <= sample;
        end
    end

    assign ext.maxV = maxQ;
    assign ext.minV = minQ;
endmodule : peak_tracker
`default_nettype wire

// ### rtl/wheel_speed_offset_calibration.sv
`timescale 1ns/1ps
`default_nettype none
module wheel_speed_offset_calibration
    import wss_pkg::*;
#(
    parameter int CalPeriods = CAL_PERIODS,
    parameter int StartupTimeout = STARTUP_TIMEOUT_CYCLES,
    parameter int PorCycles = POR_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic underVoltage,
    input wire logic [ADC_W-1:0] adcCode,
    input wire logic mainCompHigh,
    output logic [DAC_W-1:0] offsetDac,
    output logic highCurrent,
    output logic calibrated,
    output logic awake
);
    // Elaboration check: counters are sized for these ranges only
    if (CalPeriods < 1 || CalPeriods > 255 || StartupTimeout < 2 || PorCycles < 1) begin : g_bad_param
        $error("wheel_speed_offset_calibration: bad parameter");
    end

    mode_e mode_q;
    logic [31:0] porCnt_q;
    logic [31:0] toCnt_q;
    logic [7:0] periods_q;
    logic [DAC_W-1:0] dac_q;
    logic out_q;
    logic signed [ADC_W:0] sample;
    logic signed [ADC_W:0] ref_q;
    logic coreRst;
    logic timeout;
    logic signed [ADC_W:0] swing;
    logic signed [ADC_W:0] mean;
    logic upStep;
    logic downStep;
    logic calSwitch;

    extreme_if #(.W(ADC_W)) ext ();

    // Undervoltage forces the whole core back to power-up
    assign coreRst = underVoltage;

    // Tracking converter code made signed about mid-scale
    assign sample = $signed({1'b0, adcCode}) - $signed({1'b0, ADC_MID});

    peak_tracker #(.W(ADC_W)) tracker (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .enable(mode_q != PowerUp), // Tracks from the first awake cycle
        .sample(sample),
        .ext(ext)
    );

    assign swing = ext.maxV - ext.minV;
    assign mean = (ext.maxV + ext.minV) >>> 1;
    // Symmetric startup test against the reference point
    assign upStep = (sample - ref_q) > $signed({1'b0, STARTUP_NOISE_THRESHOLD});
    assign downStep = (ref_q - sample) > $signed({1'b0, STARTUP_NOISE_THRESHOLD});
    assign timeout = (toCnt_q >= 32'(StartupTimeout - 1));
    // Calibrated switching only on swings above the limit
    assign calSwitch = (swing > $signed({1'b0, SWITCHING_AMPLITUDE_LIMIT}))
        && ((out_q && sample < 0) || (!out_q && sample > 0));
    assign ext.clear = (mode_q == Uncal && (upStep || downStep || timeout)) || (mode_q == Cal && calSwitch);

    // Power-on delay then uncalibrated mode; clock is the on-chip oscillator
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= PowerUp;
            porCnt_q <= '0;
        end else if (coreRst) begin
            mode_q <= PowerUp;
            porCnt_q <= '0;
        end else begin
            case (mode_q)
                PowerUp: begin
                    porCnt_q <= porCnt_q + 32'd1;
                    if (porCnt_q >= 32'(PorCycles - 1)) mode_q <= Uncal;
                end
                Uncal: begin
                    if (timeout) mode_q <= PowerUp; // Full restart of self-calibration
                    else if (periods_q >= 8'(CalPeriods)) mode_q <= Cal;
                    porCnt_q <= '0;
                end
                default: mode_q <= Cal;
            endcase
        end
    end

    // Startup timeout counter, reset at each detected step
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) toCnt_q <= '0;
        else if (coreRst || mode_q != Uncal || upStep || downStep) toCnt_q <= '0;
        else toCnt_q <= toCnt_q + 32'd1;
    end

    // Reference point and half-period count while uncalibrated
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_q <= '0;
            periods_q <= '0;
        end else if (coreRst || mode_q == PowerUp) begin
            ref_q <= sample;
            periods_q <= '0;
        end else if (mode_q == Uncal && (upStep || downStep)) begin
            ref_q <= sample;
            if ((upStep && !out_q) || (downStep && out_q)) periods_q <= periods_q + 8'd1;
        end
    end

    // Output decision
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) out_q <= 1'b0;
        else if (coreRst || mode_q == PowerUp || (mode_q == Uncal && timeout)) out_q <= 1'b0;
        else if (mode_q == Uncal) begin
            if (upStep) out_q <= 1'b1;
            else if (downStep) out_q <= 1'b0;
        end else if (calSwitch) out_q <= ~out_q;
    end

    // Offset DAC regulation: step down on a positive mean, up on a negative one, after each swing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) dac_q <= DAC_RESET;
        // Cleared on the restart edge itself so the code never moves while asleep
        else if (coreRst || mode_q == PowerUp || (mode_q == Uncal && timeout)) dac_q <= DAC_RESET;
        else if (ext.clear && swing > 0) begin
            // Deadband in calibrated mode stops dither between adjacent codes
            if (mean > $signed((mode_q == Cal) ? (ADC_W+1)'(LOWJIT_DEADBAND) : (ADC_W+1)'(0))) begin
                if (dac_q != '0) dac_q <= dac_q - {{(DAC_W-1){1'b0}}, 1'b1};
            end else if (mean < -$signed((mode_q == Cal) ? (ADC_W+1)'(LOWJIT_DEADBAND) : (ADC_W+1)'(0))) begin
                if (dac_q != '1) dac_q <= dac_q + {{(DAC_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Current level follows the output decision one cycle later in every mode; mainCompHigh has no effect
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) highCurrent <= 1'b0;
        else if (coreRst) highCurrent <= 1'b0; // Low current at once under undervoltage
        else highCurrent <= (mode_q == Cal) ? (out_q & (mainCompHigh | out_q)) : out_q;
    end

    assign offsetDac = dac_q;
    assign calibrated = (mode_q == Cal);
    assign awake = (mode_q != PowerUp);
endmodule : wheel_speed_offset_calibration
`default_nettype wire

// ### rtl/wss_pkg.sv
package wss_pkg;
    localparam int ADC_W = 10;
    localparam int DAC_W = 8;
    localparam logic [ADC_W-1:0] ADC_MID = 10'h200;
    localparam logic [DAC_W-1:0] DAC_RESET = 8'h80;
    localparam int POR_TIME_US = 100;
    localparam int CLK_MHZ = 20;
    localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
    localparam logic [ADC_W-1:0] STARTUP_NOISE_THRESHOLD = 10'h020;
    localparam logic [ADC_W-1:0] SWITCHING_AMPLITUDE_LIMIT = 10'h010;
    localparam int CAL_PERIODS = 3;
    localparam int STARTUP_TIMEOUT_MS = 500;
    localparam int STARTUP_TIMEOUT_CYCLES = STARTUP_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int LOWJIT_DEADBAND = 2;
    typedef enum {PowerUp, Uncal, Cal} mode_e;
endpackage : wss_pkg

// ### testbench/control_unit.sv
`timescale 1ns/1ps
`default_nettype none
module control_unit (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic highCurrent,
    output logic [7:0] edgeCnt_q
);
    logic last_q;
    // Receiver only sees current level changes, so it counts them
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 1'b0;
            edgeCnt_q <= 8'h00;
        end else begin
            last_q <= highCurrent;
            edgeCnt_q <= edgeCnt_q + 8'(highCurrent != last_q);
        end
    end
endmodule : control_unit
`default_nettype wire

// ### testbench/wheel_speed_offset_calibration_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wheel_speed_offset_calibration_tb_top;
    import wss_pkg::*;
    localparam int Por = 10;
    localparam int Tmo = 200;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic underVoltage = 1'b0;
    logic [ADC_W-1:0] adcCode = ADC_MID;
    logic mainCompHigh = 1'b0;
    logic [DAC_W-1:0] offsetDac;
    logic highCurrent;
    logic calibrated;
    logic awake;
    logic [7:0] edgeCnt;
    int n_fail = 0;
    int n_tests = 0;
    // Short counts keep the run brief; expectations use the same values
    always #25 sys_clk = ~sys_clk;
    wheel_speed_offset_calibration #(.CalPeriods(3), .StartupTimeout(Tmo), .PorCycles(Por)) uut (.sys_clk(sys_clk),
        .rst_b(rst_b), .underVoltage(underVoltage), .adcCode(adcCode), .mainCompHigh(mainCompHigh),
        .offsetDac(offsetDac), .highCurrent(highCurrent), .calibrated(calibrated), .awake(awake));
    control_unit cu (.sys_clk(sys_clk), .rst_b(rst_b), .highCurrent(highCurrent), .edgeCnt_q(edgeCnt));
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    // Drives the converter code just after a falling edge, then holds it n cycles
    task automatic drv(input logic [ADC_W-1:0] v, input int n);
        @(negedge sys_clk);
        adcCode = v;
        mainCompHigh = v > ADC_MID;
        repeat (n - 1) @(negedge sys_clk);
    endtask : drv
    // Bounded wait for the wake-up flag to reach a level
    task automatic wait_awake(input logic lvl, input int lim);
        for (int i = 0; i < lim && awake !== lvl; i++) @(negedge sys_clk);
    endtask : wait_awake
    task automatic t_uncal;
        drv(ADC_MID + 10'h010, 20);
        chk(highCurrent === 1'b0, "small step switched");
        drv(ADC_MID + 10'h040, 3);
        chk(highCurrent === 1'b1, "rising step missed");
        drv(ADC_MID - 10'h040, 3);
        chk(highCurrent === 1'b0, "falling step missed");
    endtask : t_uncal
    task automatic t_cal;
        logic [7:0] n0;
        for (int i = 0; i < 12; i++) drv(i % 2 ? ADC_MID - 10'h080 : ADC_MID + 10'h080, 30);
        chk(calibrated === 1'b1, "not calibrated");
        n0 = edgeCnt;
        for (int i = 0; i < 4; i++) begin
            drv(i % 2 ? ADC_MID - 10'h080 : ADC_MID + 10'h080, 4);
            chk(highCurrent === (i % 2 == 0), "no toggle at mean");
        end
        // Receiver counts the last level change one edge later
        @(negedge sys_clk);
        chk(edgeCnt === n0 + 8'h04, "edge count");
        // Crossing from the big swing is real; after it, a swing of exactly the limit must stay quiet
        drv(ADC_MID + 10'h008, 6);
        chk(highCurrent === 1'b1, "crossing missed");
        for (int i = 0; i < 4; i++) begin
            drv(i % 2 ? ADC_MID + 10'h008 : ADC_MID - 10'h008, 6);
            chk(highCurrent === 1'b1, "small swing switched");
        end
    endtask : t_cal
    task automatic t_uv_timeout;
        drv(ADC_MID, 1);
        underVoltage = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(!awake && !calibrated && !highCurrent && offsetDac === 8'h80, "undervoltage");
        underVoltage = 1'b0;
        wait_awake(1'b1, Por + 5);
        chk(awake === 1'b1 && calibrated === 1'b0, "no uncal restart");
        wait_awake(1'b0, Tmo + 20);
        chk(awake === 1'b0, "no startup timeout");
        wait_awake(1'b1, Por + 5);
        for (int i = 1; i <= 40; i++) drv(ADC_MID + 10'(i), 3);
        chk(highCurrent === 1'b1 && calibrated === 1'b0, "slow ramp missed");
    endtask : t_uv_timeout
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        chk(offsetDac === 8'h80 && !highCurrent && !calibrated && !awake, "reset values");
        wait_awake(1'b1, Por + 5);
        chk(awake === 1'b1 && calibrated === 1'b0, "wake-up");
        t_uncal();
        t_cal();
        t_uv_timeout();
        finish_test();
    end
    // Watchdog well beyond the eight hundred or so cycles the tests need
    initial begin
        #(20000 * 50);
        n_fail++;
        finish_test();
    end
endmodule : wheel_speed_offset_calibration_tb_top
bind wheel_speed_offset_calibration wss_monitor #(.PorCycles(PorCycles)) mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .underVoltage(underVoltage), .adcCode(adcCode), .offsetDac(offsetDac), .highCurrent(highCurrent),
    .calibrated(calibrated), .awake(awake));
`default_nettype wire

// ### testbench/wss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wss_monitor
    import wss_pkg::*;
#(parameter int PorCycles = POR_CYCLES) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic underVoltage,
    input wire logic [ADC_W-1:0] adcCode,
    input wire logic [DAC_W-1:0] offsetDac,
    input wire logic highCurrent,
    input wire logic calibrated,
    input wire logic awake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    int sleepCnt_q;
    // Cycles spent asleep; undervoltage restarts the wait, as reset does
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) sleepCnt_q <= 0;
        else if (awake || underVoltage) sleepCnt_q <= 0;
        else sleepCnt_q <= sleepCnt_q + 1;
    end
    wake_delay_a: assert property ($rose(awake) |-> sleepCnt_q >= PorCycles - 2 && sleepCnt_q <= PorCycles + 2)
        else $error("wake-up delay wrong");
    uncal_start_a: assert property ($rose(awake) |-> !calibrated)
        else $error("woke calibrated");
    uv_hold_a: assert property (underVoltage |=> !awake && !calibrated && !highCurrent && offsetDac == DAC_RESET)
        else $error("undervoltage not held");
    cal_awake_a: assert property (calibrated |-> awake)
        else $error("calibrated while asleep");
    cal_loss_a: assert property ($fell(calibrated) |-> !awake)
        else $error("calibration lost while awake");
    out_awake_a: assert property ($rose(highCurrent) |-> $past(awake))
        else $error("output edge while asleep");
    dac_awake_a: assert property ($changed(offsetDac) |-> $past(awake))
        else $error("offset code moved while asleep");
    steady_out_a: assert property (($stable(adcCode) && calibrated)[*4] |-> $stable(highCurrent))
        else $error("output moved on steady input");
endmodule : wss_monitor
`default_nettype wire
